// [dv/lfs_meas_model.sv]
// Behavioural model of the measurement side that faces the sweep sequencer.
`timescale 1ns/1ps
module lfs_meas_model (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Bench controls.
   input wire logic sig_on_i,
   input wire logic rec_err_i,
   input wire logic nonrec_err_i,
   input wire logic [7:0] gap_i,
   // Source tuning from the sequencer.
   input wire logic [lfs_pkg::FW-1:0] src_freq_i,
   // Measurement results.
   output logic signal_detect_o,
   output lfs_pkg::lfs_meas_t meas_o
);
   logic [7:0] cnt;

   // Free-running measurement loop: one result every gap_i+1 cycles while a signal is present and no recoverable error holds it.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cnt <= 8'h00;
         meas_o <= '0;
         signal_detect_o <= 1'b0;
      end else begin
         signal_detect_o <= sig_on_i;
         meas_o.rec_err <= rec_err_i;
         meas_o.nonrec_err <= nonrec_err_i;
         // Without a signal the counter reading means nothing, so it wanders.
         meas_o.meas_freq <= sig_on_i ? src_freq_i : ~meas_o.meas_freq;
         if (!sig_on_i || rec_err_i || cnt >= gap_i) begin
            cnt <= 8'h00;
         end else begin
            cnt <= cnt + 8'h01;
         end
         meas_o.meas_done <= sig_on_i && !rec_err_i && cnt >= gap_i;
      end
   end
endmodule

// [dv/log_frequency_sweep_sequencer_bench.sv]
// Self-checking bench of the log sweep sequencer with a reference model of the point list.
`timescale 1ns/1ps
module log_frequency_sweep_sequencer_bench;
   logic clk = 1'b0;
   logic rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sig_on = 1'b0, rec = 1'b0, nonrec = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [3:0] sel = 4'hf;
   logic [31:0] dat = 32'h0, dat_o, rd;
   logic [7:0] gap = 8'h04;
   logic ack, det;
   logic [lfs_pkg::FW-1:0] src, last_src;
   lfs_pkg::lfs_meas_t meas;
   lfs_pkg::lfs_panel_t panel;
   int n_errors = 0, check_count = 0, cycles = 0, st = 2000, sp = 2000000, s;
   bit led = 0, mon = 0, got_done = 0;
   int q[$];

   lfs_sequencer lfs_sequencer_i (.core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .signal_detect_i(det), .meas_i(meas), .src_freq_o(src), .panel_o(panel));
   lfs_meas_model lfs_meas_model_i (.core_clk_i(clk), .rst_i(rst), .sig_on_i(sig_on), .rec_err_i(rec),
      .nonrec_err_i(nonrec), .gap_i(gap), .src_freq_i(src), .signal_detect_o(det), .meas_o(meas));

   // Clock of 100 MHz.
   always #5 clk = ~clk;

   // Prints the counts and the verdict, then ends the run.
   task stop_test;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Compares a seen value with the expected one.
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Compares a point frequency within the truncation slack of the fixed-point steps.
   task near(input int seen, input real exp);
      int e;
      e = $rtoi(exp + 0.5);
      check(32'(seen), (seen - e <= e / 400 + 4 && e - seen <= e / 400 + 4) ? 32'(seen) : 32'(e));
   endtask

   // One classic Wishbone cycle; read data lands in rd.
   task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int t;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 50);
      if (t >= 50) check(32'(ack), 32'h1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask

   // Presses one key and lets its effect reach the outputs.
   task key(input int b);
      wb(1'b1, lfs_pkg::A_KEY, 32'h1 << b);
      repeat (3) @(posedge clk);
   endtask

   // Polls the status until the sweep reaches point n.
   task wait_pt(input int n);
      int t;
      t = 0;
      do begin
         wb(1'b0, lfs_pkg::A_STATUS, 32'h0);
         t++;
      end while (rd[31:24] < n && t < 500);
   endtask

   // Programs one endpoint through its key, the entry and the unit key.
   task set_ep(input int kb, input int v);
      int old;
      old = (kb == lfs_pkg::K_LOW) ? st : sp;
      key(kb);
      check(32'(src), old);
      check(32'(panel.left_src), 32'(lfs_pkg::L_ENDPT));
      check(32'(panel.left_value), old);
      wb(1'b1, lfs_pkg::A_ENTRY, v);
      repeat (3) @(posedge clk);
      check(32'(panel.left_src), 32'(lfs_pkg::L_ENTRY));
      check(32'(panel.left_value), v);
      key(lfs_pkg::K_UNIT);
      check(32'(panel.left_src), 32'(lfs_pkg::L_MEAS));
      check(32'(src), old);
      if (kb == lfs_pkg::K_LOW) st = v; else sp = v;
      wb(1'b0, (kb == lfs_pkg::K_LOW) ? lfs_pkg::A_START : lfs_pkg::A_STOP, 32'h0);
      check(rd, v);
   endtask

   // Selects resolution code c through the special-function key.
   task set_res(input int c);
      wb(1'b1, lfs_pkg::A_ENTRY, 32'(lfs_pkg::RES_BASE) + c);
      repeat (3) @(posedge clk);
      check(32'(panel.left_src), 32'(lfs_pkg::L_ENTRY));
      check(32'(panel.left_value), 32'(lfs_pkg::RES_BASE) + c);
      key(lfs_pkg::K_SPECIAL_FUNCTION_KEY);
      led = led | (c != 0);
      check(32'(panel.special_function_key_led), 32'(led));
      check(32'(panel.left_src), 32'(lfs_pkg::L_MEAS));
      wb(1'b0, lfs_pkg::A_STATUS, 32'h0);
      check(32'(rd[23:20]), c);
   endtask

   // Runs a whole sweep and compares the recorded points with the model.
   task run(input int sv, input int pv, input int c, input bit pause);
      int k, nn, t;
      set_ep(lfs_pkg::K_LOW, sv);
      set_ep(lfs_pkg::K_HIGH, pv);
      set_res(c);
      gap <= 8'(1 + $urandom % 8);
      sig_on <= 1'b0;
      key(lfs_pkg::K_SWEEP);
      check(32'(panel.sweep_led), 32'h1);
      repeat (30) @(posedge clk);
      check(32'(src), sv);
      q.delete();
      mon = 1;
      sig_on <= 1'b1;
      if (pause) begin
         wait_pt(3);
         rec <= 1'b1;
         repeat (5) @(posedge clk);
         wb(1'b0, lfs_pkg::A_STATUS, 32'h0);
         t = rd[31:24];
         check(32'(rd[2]), 32'h1);
         check(32'(rd[0]), 32'h1);
         repeat (40) @(posedge clk);
         wb(1'b0, lfs_pkg::A_STATUS, 32'h0);
         check(32'(rd[31:24]), t);
         rec <= 1'b0;
      end
      t = 0;
      while (panel.sweep_led !== 1'b0 && t < 20000) begin
         @(posedge clk);
         t++;
      end
      mon = 0;
      check(32'(panel.sweep_led), 32'h0);
      k = lfs_pkg::PPD[c];
      nn = $rtoi(k * $log10((sv > pv) ? real'(sv) / pv : real'(pv) / sv) + 0.5);
      if (nn > 254) nn = 254;
      check(q.size(), nn + 1);
      foreach (q[n]) if (n < nn) near(q[n], sv * 10.0 ** (((sv > pv) ? -n : n) / real'(k)));
      if (q.size() > 0) check(q[q.size() - 1], pv);
   endtask

   // Records each new point at its measurement and checks that steps follow a finished measurement.
   always @(posedge clk) begin
      cycles++;
      if (cycles > 80000) begin
         n_errors++;
         stop_test();
      end
      if (mon && src !== last_src) begin
         check(32'(got_done), 32'h1);
         got_done = 0;
      end
      if (mon && meas.meas_done === 1'b1) begin
         got_done = 1;
         if (q.size() == 0 || q[$] != src) q.push_back(src);
      end
      last_src = src;
      if (!mon) got_done = 0;
   end

   // Main sequence.
   initial begin
      int kinds[5];
      kinds = '{lfs_pkg::K_CLEAR, lfs_pkg::K_PRESET, lfs_pkg::K_HIGH, lfs_pkg::K_LOW, lfs_pkg::K_SWEEP};
      void'($urandom(32'h539f));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wb(1'b0, lfs_pkg::A_START, 32'h0);
      check(rd, 32'h7d0);
      wb(1'b0, lfs_pkg::A_STOP, 32'h0);
      check(rd, 32'h1e8480);
      wb(1'b0, lfs_pkg::A_STATUS, 32'h0);
      check(32'(rd[23:20]), 32'h0);
      wb(1'b0, 5'h18, 32'h0);
      check(rd, 32'h0);
      set_ep(lfs_pkg::K_LOW, 2000 + $urandom % 9998000);
      for (int c = 0; c < 10; c++) set_res(c);
      run(5000, 3000000, 3, 1'b1);
      run(3000000, 5000, 3, 1'b0);
      run(200000, 10000000, 9, 1'b0);
      // Interrupts a paused sweep with each key that may act during a sweep.
      sig_on <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         key(lfs_pkg::K_SWEEP);
         wait_pt(2);
         rec <= 1'b1;
         repeat (5) @(posedge clk);
         wb(1'b0, lfs_pkg::A_SOURCE, 32'h0);
         s = rd;
         key(kinds[i]);
         check(32'(src), i < 2 ? s : i == 2 ? sp : st);
         check(32'(panel.sweep_led), 32'(i == 4));
         if (i == 4) begin
            wb(1'b0, lfs_pkg::A_STATUS, 32'h0);
            check(32'(rd[31:24]), 32'h0);
            key(lfs_pkg::K_CLEAR);
         end
         rec <= 1'b0;
         repeat (30) @(posedge clk);
         check(32'(src), i < 2 ? s : i == 2 ? sp : st);
      end
      // Nonrecoverable error in mid-sweep.
      key(lfs_pkg::K_SWEEP);
      wait_pt(2);
      nonrec <= 1'b1;
      repeat (5) @(posedge clk);
      wb(1'b0, lfs_pkg::A_SOURCE, 32'h0);
      s = rd;
      key(lfs_pkg::K_SWEEP);
      key(lfs_pkg::K_ERRCLR);
      wb(1'b0, lfs_pkg::A_STATUS, 32'h0);
      check(32'(rd[3]), 32'h1);
      nonrec <= 1'b0;
      repeat (30) @(posedge clk);
      check(32'(src), s);
      key(lfs_pkg::K_ERRCLR);
      sig_on <= 1'b0;
      key(lfs_pkg::K_SWEEP);
      check(32'(src), st);
      wb(1'b0, lfs_pkg::A_STATUS, 32'h0);
      check(32'(rd[3]), 32'h0);
      check(32'(rd[31:24]), 32'h0);
      check(32'(rd[0]), 32'h1);
      key(lfs_pkg::K_CLEAR);
      stop_test();
   end
endmodule

// [src/lfs_pkg.sv]
// Constants, lookup tables and carrier types of the log sweep sequencer.
package lfs_pkg;
   // ----------------------------------------------------------------
   // Widths and power-up values
   // ----------------------------------------------------------------
   localparam int FW = 26;                            // Frequency word, units of 0.01 Hz.
   localparam int QF = 20;                            // Fraction bits of step ratios.
   localparam int PW = 8;                             // Point index width.
   localparam int NK = 8;                             // Number of key bits.
   localparam int NRES = 10;                          // Number of resolution codes.
   localparam logic [FW-1:0] START_PU = 26'h00007d0;  // 20 Hz.
   localparam logic [FW-1:0] STOP_PU = 26'h01e8480;   // 20 kHz.
   localparam logic [FW-1:0] RES_BASE = 26'h00000aa;  // Entry value 170 selects code 17.0.
   localparam logic [3:0] RES_PU = 4'h0;              // Code 17.0, ten points per decade.
   localparam int MAX_POINTS = 255;

   // ----------------------------------------------------------------
   // Register map and key bits
   // ----------------------------------------------------------------
   localparam logic [4:0] A_KEY = 5'h00;
   localparam logic [4:0] A_ENTRY = 5'h04;
   localparam logic [4:0] A_START = 5'h08;
   localparam logic [4:0] A_STOP = 5'h0c;
   localparam logic [4:0] A_STATUS = 5'h10;
   localparam logic [4:0] A_SOURCE = 5'h14;
   localparam int K_LOW = 0;
   localparam int K_HIGH = 1;
   localparam int K_SWEEP = 2;
   localparam int K_CLEAR = 3;
   localparam int K_PRESET = 4;
   localparam int K_UNIT = 5;
   localparam int K_SPECIAL_FUNCTION_KEY = 6;
   localparam int K_ERRCLR = 7;

   // Left display sources and endpoint under edit.
   localparam logic [1:0] L_MEAS = 2'h0;
   localparam logic [1:0] L_ENDPT = 2'h1;
   localparam logic [1:0] L_ENTRY = 2'h2;
   localparam logic [1:0] E_NONE = 2'h0;
   localparam logic [1:0] E_LOW = 2'h1;
   localparam logic [1:0] E_HIGH = 2'h2;

   // ----------------------------------------------------------------
   // Resolution tables
   // ----------------------------------------------------------------
   localparam int PPD [NRES] = '{10, 1, 2, 5, 10, 20, 50, 100, 200, 500};
   typedef logic [FW-1:0] lfs_tab_t [NRES];

   // Builds ten raised to e/k in fixed point for every resolution code.
   function automatic lfs_tab_t lfs_ratio_tab(real e);
      lfs_tab_t t;
      for (int c = 0; c < NRES; c++) begin
         t[c] = FW'($rtoi(10.0 ** (e / real'(PPD[c])) * real'(1 << QF) + 0.5));
      end
      return t;
   endfunction

   localparam lfs_tab_t STEP_UP = lfs_ratio_tab(1.0);
   localparam lfs_tab_t STEP_DN = lfs_ratio_tab(-1.0);
   localparam lfs_tab_t HALF_UP = lfs_ratio_tab(0.5);
   localparam lfs_tab_t HALF_DN = lfs_ratio_tab(-0.5);

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic meas_done;
      logic rec_err;
      logic nonrec_err;
      logic [FW-1:0] meas_freq;
   } lfs_meas_t;

   typedef struct packed {
      logic sweep_led;
      logic special_function_key_led;
      logic [1:0] left_src;
      logic [FW-1:0] left_value;
   } lfs_panel_t;

   typedef struct packed {
      logic [PW-1:0] point;
      logic [3:0] res;
      logic [12:0] rsvd;
      logic last;
      logic down;
      logic special_function_key;
      logic err;
      logic paused;
      logic stepping;
      logic sweep_mode;
   } lfs_status_t;
endpackage

// [src/lfs_sequencer.sv]
// Log frequency sweep sequencer with a classic Wishbone register slave.
`timescale 1ns/1ps

module lfs_sequencer (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Measurement side.
   input wire logic signal_detect_i,
   input wire lfs_pkg::lfs_meas_t meas_i,
   // Source and front panel.
   output logic [lfs_pkg::FW-1:0] src_freq_o,
   output lfs_pkg::lfs_panel_t panel_o
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_ARM = 5'h02,
      S_MEAS = 5'h04,
      S_CALC = 5'h08,
      S_CHK = 5'h10
   } lfs_state_t;

   lfs_state_t state;
   logic [1:0] sig_sync;
   logic wr;
   logic entry_wr;
   logic [lfs_pkg::NK-1:0] kv;
   logic [31:0] next_entry;
   logic [lfs_pkg::FW-1:0] entry;
   logic [lfs_pkg::FW-1:0] low_endpoint_key;
   logic [lfs_pkg::FW-1:0] high_endpoint_key;
   logic [lfs_pkg::FW-1:0] src;
   logic [lfs_pkg::FW+1:0] test_w;
   logic [lfs_pkg::PW-1:0] point;
   logic [3:0] res;
   logic [1:0] left_src;
   logic [1:0] edit;
   logic special_function_key_led;
   logic sweep_mode;
   logic err_flag;
   logic down;
   logic last;
   logic hit;
   logic start_ok;
   logic abort;
   logic to_stop;
   lfs_pkg::lfs_status_t status;

   // Fixed-point multiply of a frequency by a Q.20 ratio, kept two bits wider than the frequency word.
   function automatic logic [lfs_pkg::FW+1:0] scale(logic [lfs_pkg::FW-1:0] f, logic [lfs_pkg::FW-1:0] r);
      logic [2*lfs_pkg::FW-1:0] p;
      p = f * r;
      return p[lfs_pkg::QF+lfs_pkg::FW+1:lfs_pkg::QF];
   endfunction

   // True when the bus addresses the given register.
   function automatic logic reg_hit(logic [4:0] a, logic [4:0] ref_a);
      return a == ref_a;
   endfunction

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   // Writes commit on the edge that sees ack, so each takes effect once.
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign entry_wr = wr && reg_hit(wb_adr_i, lfs_pkg::A_ENTRY);
   assign kv = (wr && reg_hit(wb_adr_i, lfs_pkg::A_KEY) && wb_sel_i[0]) ? wb_dat_i[lfs_pkg::NK-1:0] : '0;

   // Byte lanes of the entry register follow the select lines.
   always_comb begin
      next_entry = 32'(entry);
      for (int b = 0; b < 4; b++) begin
         if (entry_wr && wb_sel_i[b]) begin
            next_entry[b*8 +: 8] = wb_dat_i[b*8 +: 8];
         end
      end
   end

   // Status word gathers the sequencer state.
   always_comb begin
      status = '0;
      status.point = point;
      status.res = res;
      status.last = last;
      status.down = down;
      status.special_function_key = special_function_key_led;
      status.err = err_flag;
      status.paused = sweep_mode && meas_i.rec_err;
      status.stepping = sweep_mode && !meas_i.rec_err && state != S_ARM;
      status.sweep_mode = sweep_mode;
   end

   // Ack is one cycle after the request and drops the cycle after.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         case (wb_adr_i)
            lfs_pkg::A_ENTRY: wb_dat_o <= 32'(entry);
            lfs_pkg::A_START: wb_dat_o <= 32'(low_endpoint_key);
            lfs_pkg::A_STOP: wb_dat_o <= 32'(high_endpoint_key);
            lfs_pkg::A_STATUS: wb_dat_o <= status;
            lfs_pkg::A_SOURCE: wb_dat_o <= 32'(src);
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Keyboard entry and display
   // ----------------------------------------------------------------
   // Input detect comes from a pin and is synchronised first.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sig_sync <= 2'h0;
      end else begin
         sig_sync <= {sig_sync[0], signal_detect_i};
      end
   end

   // Entry register holds the value being keyed in.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         entry <= '0;
      end else begin
         entry <= next_entry[lfs_pkg::FW-1:0];
      end
   end

   // Left display source and the endpoint being edited.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         left_src <= lfs_pkg::L_MEAS;
         edit <= lfs_pkg::E_NONE;
      end else if (kv[lfs_pkg::K_LOW]) begin
         left_src <= lfs_pkg::L_ENDPT;
         edit <= lfs_pkg::E_LOW;
      end else if (kv[lfs_pkg::K_HIGH]) begin
         left_src <= lfs_pkg::L_ENDPT;
         edit <= lfs_pkg::E_HIGH;
      end else if (kv[lfs_pkg::K_UNIT] || kv[lfs_pkg::K_SPECIAL_FUNCTION_KEY]) begin
         left_src <= lfs_pkg::L_MEAS;
         edit <= lfs_pkg::E_NONE;
      end else if (entry_wr) begin
         left_src <= lfs_pkg::L_ENTRY;
      end
   end

   // Unit key programs the endpoint under edit; the source is not moved.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         low_endpoint_key <= lfs_pkg::START_PU;
         high_endpoint_key <= lfs_pkg::STOP_PU;
      end else if (kv[lfs_pkg::K_UNIT] && edit == lfs_pkg::E_LOW) begin
         low_endpoint_key <= entry;
      end else if (kv[lfs_pkg::K_UNIT] && edit == lfs_pkg::E_HIGH) begin
         high_endpoint_key <= entry;
      end
   end

   // Special key with entry 170 to 179 selects the resolution code.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         res <= lfs_pkg::RES_PU;
         special_function_key_led <= 1'b0;
      end else if (kv[lfs_pkg::K_SPECIAL_FUNCTION_KEY] && entry >= lfs_pkg::RES_BASE &&
                   entry < lfs_pkg::RES_BASE + lfs_pkg::FW'(lfs_pkg::NRES)) begin
         res <= 4'(entry - lfs_pkg::RES_BASE);
         if (entry != lfs_pkg::RES_BASE) begin
            special_function_key_led <= 1'b1;
         end
      end
   end

   // Panel outputs are registered copies of the display state.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         panel_o <= '0;
      end else begin
         panel_o.sweep_led <= sweep_mode;
         panel_o.special_function_key_led <= special_function_key_led;
         panel_o.left_src <= left_src;
         case (left_src)
            lfs_pkg::L_ENDPT: panel_o.left_value <= (edit == lfs_pkg::E_HIGH) ? high_endpoint_key : low_endpoint_key;
            lfs_pkg::L_ENTRY: panel_o.left_value <= entry;
            default: panel_o.left_value <= meas_i.meas_freq;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Error latch
   // ----------------------------------------------------------------
   // A present cause keeps the flag set against the clear key.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         err_flag <= 1'b0;
      end else if (meas_i.nonrec_err) begin
         err_flag <= 1'b1;
      end else if (kv[lfs_pkg::K_ERRCLR]) begin
         err_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Sweep sequencer
   // ----------------------------------------------------------------
   assign start_ok = kv[lfs_pkg::K_SWEEP] && !err_flag && !meas_i.nonrec_err;
   assign abort = kv[lfs_pkg::K_CLEAR] || kv[lfs_pkg::K_PRESET] || meas_i.nonrec_err;

   // A point is last once half a step more reaches the stop, which rounds the count.
   assign test_w = scale(src, down ? lfs_pkg::HALF_DN[res] : lfs_pkg::HALF_UP[res]);
   assign hit = (down ? (test_w <= {2'b00, high_endpoint_key}) : (test_w >= {2'b00, high_endpoint_key})) ||
                src == high_endpoint_key || point == lfs_pkg::PW'(lfs_pkg::MAX_POINTS - 1);

   // The checked point is the last one and no key or nonrecoverable error overrides the sequencer this cycle.
   assign to_stop = state == S_CHK && hit && !abort && !start_ok && !kv[lfs_pkg::K_LOW] && !kv[lfs_pkg::K_HIGH];

   // Sweep state, source frequency and point index.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         sweep_mode <= 1'b0;
         src <= lfs_pkg::START_PU;
         point <= '0;
         down <= 1'b0;
         last <= 1'b0;
      end else if (abort) begin
         state <= S_IDLE;
         sweep_mode <= 1'b0;
      end else if (start_ok) begin
         state <= S_CHK;
         sweep_mode <= 1'b1;
         src <= low_endpoint_key;
         point <= '0;
         down <= low_endpoint_key > high_endpoint_key;
      end else if (kv[lfs_pkg::K_LOW] || kv[lfs_pkg::K_HIGH]) begin
         state <= S_IDLE;
         sweep_mode <= 1'b0;
         src <= kv[lfs_pkg::K_LOW] ? low_endpoint_key : high_endpoint_key;
      end else begin
         case (state)
            S_IDLE: begin
               state <= S_IDLE;
            end
            // Holds at the start until the input sees a signal and no recoverable error holds the measurement.
            S_ARM: begin
               if (sig_sync[1] && !meas_i.rec_err) begin
                  state <= S_MEAS;
               end
            end
            S_MEAS: begin
               if (meas_i.meas_done && !meas_i.rec_err) begin
                  if (last) begin
                     state <= S_IDLE;
                     sweep_mode <= 1'b0;
                  end else begin
                     state <= S_CALC;
                  end
               end
            end
            S_CALC: begin
               src <= lfs_pkg::FW'(scale(src, down ? lfs_pkg::STEP_DN[res] : lfs_pkg::STEP_UP[res]));
               point <= point + 1'b1;
               state <= S_CHK;
            end
            S_CHK: begin
               last <= hit;
               if (hit) begin
                  src <= high_endpoint_key;
               end
               state <= (point == '0) ? S_ARM : S_MEAS;
            end
            default: begin
               state <= S_IDLE;
               sweep_mode <= 1'b0;
            end
         endcase
      end
   end

   // Source tuning word trails the internal source by a cycle; on the last point it goes
   // straight to the stop, so the output steps once; it shows the unrounded value only if a key or nonrecoverable error overrides that cycle.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         src_freq_o <= lfs_pkg::START_PU;
      end else begin
         src_freq_o <= to_stop ? high_endpoint_key : src;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence start_s;
      $onehot(kv) && kv[lfs_pkg::K_SWEEP] && !err_flag && !meas_i.nonrec_err;
   endsequence

   sequence quiet_s;
      kv == '0 && !meas_i.nonrec_err;
   endsequence

   sequence paused_s;
      state == S_MEAS && meas_i.rec_err ##0 quiet_s;
   endsequence

   power_up_a: assert property ($past(rst_i) |-> low_endpoint_key == lfs_pkg::START_PU &&
         high_endpoint_key == lfs_pkg::STOP_PU && res == lfs_pkg::RES_PU)
      else $error("Power-up endpoints or resolution wrong.");
   endpoint_tune_a: assert property ($onehot(kv) && kv[lfs_pkg::K_LOW] |=>
         src == $past(low_endpoint_key) && !sweep_mode ##1 panel_o.left_src == lfs_pkg::L_ENDPT)
      else $error("Endpoint key did not tune source.");
   sweep_start_a: assert property (start_s |=> sweep_mode && point == '0 &&
         src == $past(low_endpoint_key) ##1 panel_o.sweep_led)
      else $error("Sweep key did not start a fresh sweep.");
   abort_hold_a: assert property (sweep_mode && $onehot(kv) && (kv[lfs_pkg::K_CLEAR] ||
         kv[lfs_pkg::K_PRESET]) |=> !sweep_mode && $stable(src) && state == S_IDLE)
      else $error("Abort moved source or left sweep on.");
   pause_point_a: assert property (paused_s |=> $stable(point) && sweep_mode && state == S_MEAS)
      else $error("Recoverable error did not pause.");
   nonrec_block_a: assert property (err_flag && kv[lfs_pkg::K_SWEEP] && !sweep_mode |=> !sweep_mode)
      else $error("Sweep started under error.");
   res_select_a: assert property ($onehot(kv) && kv[lfs_pkg::K_SPECIAL_FUNCTION_KEY] &&
         entry == lfs_pkg::RES_BASE + 26'h0000001 |=> res == 4'h1 && special_function_key_led ##1 panel_o.special_function_key_led)
      else $error("Resolution code not applied.");
   max_point_a: assert property (point <= lfs_pkg::PW'(lfs_pkg::MAX_POINTS - 1))
      else $error("Point index beyond limit.");
   final_stop_a: assert property (state == S_MEAS && last |-> src == high_endpoint_key)
      else $error("Final point is not the stop frequency.");
   arm_hold_a: assert property (state == S_ARM && !sig_sync[1] ##0 quiet_s |=>
         state == S_ARM && $stable(src))
      else $error("Stepped before signal sensed.");
   step_dir_a: assert property (state == S_CALC ##0 quiet_s |=>
         (down ? src < $past(src) : src > $past(src)) && state == S_CHK)
      else $error("Step went the wrong way.");
   sweep_end_a: assert property (state == S_MEAS && last && meas_i.meas_done &&
         !meas_i.rec_err ##0 quiet_s |=> !sweep_mode ##1 !panel_o.sweep_led)
      else $error("Sweep mode not cleared at end.");
endmodule
